// ---- nfbpi_pkg.sv ----
// Constants and types for the NOR flash bus pin interface.
// Assumes one 20 MHz clock; every pin is synchronous to it.
// Function
// RL1 - Address width follows the die density.
// RL2 - Sixteen-bit data in on writes, out on reads.
// RL3 - Sync read: address on strobe rise or clock.
// RL4 - Async: strobe low flows, strobe rise latches.
// RL5 - Unused address strobe is held low.
// RL6 - Deselected die floats data and not-ready.
// RL7 - Controller holds selects high when idle.
// RL8 - Unused bus clock tied to fixed level.
// RL9 - Output enable high floats data and not-ready.
// RL10 - Both output enables are wired together.
// RL11 - Reset clears automation and blocks writes.
// RL12 - Leaving reset gives asynchronous read mode.
// RL13 - Config bit ten sets not-ready polarity.
// RL14 - Sync reads flag not-ready while data invalid.
// RL15 - Not-ready idle in async and write modes.
// RL16 - Write strobe rise captures address and data.
package nfbpi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_MAX_W = 25;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned RCR_W = 16;
  localparam int unsigned RCR_POL_BIT = 10;

  localparam int unsigned ADDR_W_64M = 22;
  localparam int unsigned ADDR_W_128M = 23;
  localparam int unsigned ADDR_W_256M = 24;
  localparam int unsigned ADDR_W_512M = 25;

  typedef enum logic [1:0] {
    DENS_64M = 2'h0,
    DENS_128M = 2'h1,
    DENS_256M = 2'h2,
    DENS_512M = 2'h3
  } nfbpi_dens_e;

  typedef enum logic {
    MODE_ASYNC = 1'h0,
    MODE_SYNC = 1'h1
  } nfbpi_mode_e;

  localparam nfbpi_mode_e MODE_RST = MODE_ASYNC;
  localparam logic [ADDR_MAX_W-1:0] ADDR_RST = 25'h0000000;
  localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;

  function automatic int unsigned nfbpi_addr_w(nfbpi_dens_e d);
    int unsigned w;
    w = ADDR_W_512M;
    case (d)
      DENS_64M: w = ADDR_W_64M;
      DENS_128M: w = ADDR_W_128M;
      DENS_256M: w = ADDR_W_256M;
      default: w = ADDR_W_512M;
    endcase
    return w;
  endfunction

endpackage

// ---- nfbpi_top.sv ----
// Pin-side logic of one NOR flash die: address and write capture, output drive control and not-ready.
// Assumes all pins are sampled on REF_CLK and that the array and command logic sit on the user ports.
module nfbpi_top import nfbpi_pkg::*; #(
  parameter nfbpi_dens_e DENSITY = DENS_512M
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic BUS_CLK,
  input wire logic [ADDR_MAX_W-1:0] ADDR,
  input wire logic ADDR_VALID_STROBE_N,
  input wire logic DIE_SELECT_FIRST_N,
  input wire logic DIE_SELECT_SECOND_N,
  input wire logic OUTPUT_DRIVE_ENABLE_FIRST_N,
  input wire logic OUTPUT_DRIVE_ENABLE_SECOND_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [DQ_W-1:0] DQ_IN,
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE,
  output logic NOT_READY_OUT,
  output logic NOT_READY_OE,
  input wire logic SYNC_MODE_REQ,
  input wire logic ASYNC_MODE_REQ,
  input wire logic [RCR_W-1:0] READ_CONFIG,
  input wire logic [DQ_W-1:0] RD_DATA,
  input wire logic RD_DATA_VALID,
  output logic [ADDR_MAX_W-1:0] RD_ADDR,
  output logic RD_ADDR_STB,
  output logic WR_STB,
  output logic [ADDR_MAX_W-1:0] WR_ADDR,
  output logic [DQ_W-1:0] WR_DATA,
  output logic DIE_ACTIVE,
  output logic READ_MODE
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned AW = nfbpi_addr_w(DENSITY);
  localparam logic [ADDR_MAX_W-1:0] AMASK = ADDR_MAX_W'((33'h1 << AW) - 33'h1);

  nfbpi_mode_e mode_r;
  logic avs_q_r;
  logic bclk_q_r;
  logic we_q_r;
  logic [ADDR_MAX_W-1:0] addr_q_r;
  logic [DQ_W-1:0] dq_q_r;
  logic taken_r;
  logic [ADDR_MAX_W-1:0] rd_addr_r;
  logic rd_stb_r;
  logic wr_stb_r;
  logic [ADDR_MAX_W-1:0] wr_addr_r;
  logic [DQ_W-1:0] wr_data_r;
  logic [DQ_W-1:0] dq_out_r;
  logic dq_oe_r;
  logic nr_out_r;
  logic nr_oe_r;
  logic sel;
  logic oe_low;
  logic drive_en;
  logic avs_rise;
  logic bclk_rise;
  logic we_rise;
  logic nr_assert;
  logic pol;

  // The two output enables are meant to be one net; either one low opens the drivers.
  assign sel = !DIE_SELECT_FIRST_N || !DIE_SELECT_SECOND_N;
  assign oe_low = !OUTPUT_DRIVE_ENABLE_FIRST_N || !OUTPUT_DRIVE_ENABLE_SECOND_N;
  assign drive_en = sel && oe_low && WRITE_STROBE_N;
  assign avs_rise = !avs_q_r && ADDR_VALID_STROBE_N;
  assign bclk_rise = !bclk_q_r && BUS_CLK;
  assign we_rise = !we_q_r && WRITE_STROBE_N;
  assign pol = READ_CONFIG[RCR_POL_BIT];
  assign nr_assert = (mode_r == MODE_SYNC) && drive_en && !RD_DATA_VALID;

  ////////////////////////////////////////////////////////////////////////////
  // Previous pin samples; edges are seen as a change between two samples.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      avs_q_r <= 1'h1;
      bclk_q_r <= 1'h0;
      we_q_r <= 1'h1;
      addr_q_r <= ADDR_RST;
      dq_q_r <= DQ_RST;
    end else if (CLK_EN) begin
      avs_q_r <= ADDR_VALID_STROBE_N;
      bclk_q_r <= BUS_CLK;
      we_q_r <= WRITE_STROBE_N;
      addr_q_r <= ADDR;
      dq_q_r <= DQ_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mode; reset always lands in asynchronous array reads.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      mode_r <= MODE_RST; // RL12
    end else if (CLK_EN) begin
      if (SYNC_MODE_REQ) begin
        mode_r <= MODE_SYNC;
      end else if (ASYNC_MODE_REQ) begin
        mode_r <= MODE_ASYNC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read address capture. A system without the strobe holds it low, so async addresses just flow.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      rd_addr_r <= ADDR_RST;
      rd_stb_r <= 1'h0;
      taken_r <= 1'h0;
    end else if (CLK_EN) begin
      rd_stb_r <= 1'h0;
      case (mode_r)
        MODE_ASYNC: begin
          taken_r <= 1'h0;
          if (!ADDR_VALID_STROBE_N) begin
            rd_addr_r <= ADDR & AMASK; // RL4 RL5 RL1
          end
        end
        MODE_SYNC: begin
          if (sel && avs_rise && !taken_r) begin
            rd_addr_r <= addr_q_r & AMASK; // RL3
            rd_stb_r <= 1'h1;
          end else if (sel && !ADDR_VALID_STROBE_N && bclk_rise && !taken_r) begin
            rd_addr_r <= ADDR & AMASK; // RL3
            rd_stb_r <= 1'h1;
            taken_r <= 1'h1;
          end
          if (ADDR_VALID_STROBE_N) begin
            taken_r <= 1'h0;
          end
        end
        default: begin
          taken_r <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write capture on the strobe's rising edge; the values held while it was low are taken.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      wr_stb_r <= 1'h0; // RL11
      wr_addr_r <= ADDR_RST;
      wr_data_r <= DQ_RST;
    end else if (CLK_EN) begin
      wr_stb_r <= sel && we_rise; // RL16
      if (sel && we_rise) begin
        wr_addr_r <= addr_q_r & AMASK; // RL16
        wr_data_r <= dq_q_r; // RL2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers and not-ready. Both float unless selected with outputs enabled and the write strobe high.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      dq_out_r <= DQ_RST;
      dq_oe_r <= 1'h0;
      nr_out_r <= 1'h0;
      nr_oe_r <= 1'h0;
    end else if (CLK_EN) begin
      dq_out_r <= RD_DATA; // RL2
      dq_oe_r <= drive_en; // RL6 RL9
      nr_oe_r <= drive_en; // RL6 RL9
      nr_out_r <= nr_assert ? pol : !pol; // RL13 RL14 RL15
    end
  end

  assign DQ_OUT = dq_out_r;
  assign DQ_OE = dq_oe_r;
  assign NOT_READY_OUT = nr_out_r;
  assign NOT_READY_OE = nr_oe_r;
  assign RD_ADDR = rd_addr_r;
  assign RD_ADDR_STB = rd_stb_r;
  assign WR_STB = wr_stb_r;
  assign WR_ADDR = wr_addr_r;
  assign WR_DATA = wr_data_r;
  assign DIE_ACTIVE = sel;
  assign READ_MODE = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Bits above the density's width must never show on a captured address.
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  property p_addr_w;
    ((RD_ADDR | WR_ADDR) & ~AMASK) == ADDR_RST;
  endproperty
  a_addr_w: assert property (p_addr_w) else $error("Captured address exceeds density width."); // RL1

  property p_drive;
    CLK_EN && drive_en |=> DQ_OE && NOT_READY_OE && DQ_OUT == $past(RD_DATA);
  endproperty
  a_drive: assert property (p_drive) else $error("Data not driven during a read."); // RL2

  property p_oe_off;
    CLK_EN && !oe_low |=> !DQ_OE && !NOT_READY_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Drivers on with output enable high."); // RL9

  property p_desel;
    CLK_EN && !sel |=> !DQ_OE && !NOT_READY_OE && !WR_STB && !RD_ADDR_STB;
  endproperty
  a_desel: assert property (p_desel) else $error("Deselected die is active."); // RL6

  property p_sync_rise;
    CLK_EN && mode_r == MODE_SYNC && sel && avs_rise && !taken_r
      |=> RD_ADDR_STB && RD_ADDR == ($past(addr_q_r) & AMASK);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("Strobe rise did not capture."); // RL3

  property p_sync_clk;
    CLK_EN && mode_r == MODE_SYNC && sel && !ADDR_VALID_STROBE_N && bclk_rise && !taken_r
      |=> RD_ADDR_STB && RD_ADDR == ($past(ADDR) & AMASK) && taken_r;
  endproperty
  a_sync_clk: assert property (p_sync_clk) else $error("Bus clock edge did not capture."); // RL3

  property p_async_flow;
    CLK_EN && mode_r == MODE_ASYNC && !ADDR_VALID_STROBE_N |=> RD_ADDR == ($past(ADDR) & AMASK);
  endproperty
  a_async_flow: assert property (p_async_flow) else $error("Async address did not flow."); // RL4

  property p_async_hold;
    mode_r == MODE_ASYNC && ADDR_VALID_STROBE_N |=> $stable(RD_ADDR);
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("Latched async address moved."); // RL4

  property p_rst;
    @(posedge REF_CLK) disable iff (1'b0) !RST_B |=> READ_MODE == MODE_ASYNC && !WR_STB && !DQ_OE;
  endproperty
  a_rst: assert property (p_rst) else $error("Reset did not clear mode or writes."); // RL11

  property p_nr_wait;
    CLK_EN && mode_r == MODE_SYNC && drive_en && !RD_DATA_VALID |=> NOT_READY_OUT == $past(pol);
  endproperty
  a_nr_wait: assert property (p_nr_wait) else $error("Not-ready missing or wrong level."); // RL14

  property p_nr_idle;
    CLK_EN && (mode_r == MODE_ASYNC || !WRITE_STROBE_N || RD_DATA_VALID) |=> NOT_READY_OUT != $past(pol);
  endproperty
  a_nr_idle: assert property (p_nr_idle) else $error("Not-ready asserted when idle."); // RL15

  property p_wr;
    CLK_EN && sel && we_rise |=> WR_STB && WR_DATA == $past(dq_q_r) && WR_ADDR == ($past(addr_q_r) & AMASK);
  endproperty
  a_wr: assert property (p_wr) else $error("Write strobe rise not captured."); // RL16

  c_sync_clk: cover property (CLK_EN && mode_r == MODE_SYNC && bclk_rise && !ADDR_VALID_STROBE_N && sel);
  c_write: cover property (WR_STB);
  c_wait: cover property (NOT_READY_OE && NOT_READY_OUT == pol);
  c_flow: cover property (mode_r == MODE_ASYNC && !ADDR_VALID_STROBE_N ##1 ADDR_VALID_STROBE_N);

endmodule

// ---- nfbpi_ctrl_model.sv ----
// Memory controller model that drives the flash pins.
// Assumes REF_CLK runs free; every pin moves 1 ns after its rising edge.
module nfbpi_ctrl_model import nfbpi_pkg::*; (
  input wire logic ref_clk,
  output logic bus_clk,
  output logic [ADDR_MAX_W-1:0] addr,
  output logic adv_n,
  output logic sel1_n,
  output logic sel2_n,
  output logic oe_n,
  output logic we_n,
  output logic [DQ_W-1:0] dq_in
);
  ////////////////////////////////////////
  initial begin
    bus_clk = 1'h0;
    adv_n = 1'h0;
    sel1_n = 1'h1;
    sel2_n = 1'h1;
    oe_n = 1'h1;
    we_n = 1'h1;
    addr = 25'h0000000;
    dq_in = 16'hffff;
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic pins(input logic [1:0] s, input logic oe, input logic adv, input logic [ADDR_MAX_W-1:0] a);
    step();
    {sel2_n, sel1_n} = s;
    oe_n = oe;
    adv_n = adv;
    addr = a;
  endtask
  ////////////////////////////////////////
  // Released data lines show the inverse, so a stale sample cannot pass as a match.
  task automatic wr(input logic [1:0] s, input logic [ADDR_MAX_W-1:0] a, input logic [DQ_W-1:0] d);
    step();
    {sel2_n, sel1_n} = s;
    addr = a;
    dq_in = d;
    we_n = 1'h0;
    step();
    we_n = 1'h1;
    step();
    sel1_n = 1'h1;
    sel2_n = 1'h1;
    dq_in = ~d;
  endtask
  task automatic cap(input logic [ADDR_MAX_W-1:0] a);
    step();
    sel1_n = 1'h0;
    addr = a;
    step();
    bus_clk = 1'h1;
    step();
    addr = ~a;
    adv_n = 1'h1;
    step();
    bus_clk = 1'h0;
    adv_n = 1'h0;
    sel1_n = 1'h1;
  endtask
  // Sync capture by the strobe's rise alone; the bus clock stays low, so only the rise can take the address.
  task automatic rise(input logic [ADDR_MAX_W-1:0] a);
    step();
    sel1_n = 1'h0;
    addr = a;
    step();
    adv_n = 1'h1;
    addr = ~a;
    step();
    adv_n = 1'h0;
    sel1_n = 1'h1;
  endtask
endmodule

// ---- nfbpi_top_tb.sv ----
// Self-checking bench for the pin interface, with the controller model on the pins.
// Assumes the model and the bench move inputs 1 ns after REF_CLK rises.
module nfbpi_top_tb import nfbpi_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [ADDR_MAX_W-1:0] a; logic [DQ_W-1:0] d;} nfbpi_exp_s;
  localparam logic [ADDR_MAX_W-1:0] AMASK = 25'h0ffffff;
  logic ref_clk = 1'h0, rst_b = 1'h0, sync_req = 1'h0, async_req = 1'h0, rd_vld = 1'h0;
  logic [RCR_W-1:0] rcfg = 16'h0000;
  logic [DQ_W-1:0] rd_data = 16'h0000, dq_in, dq_out, wr_data;
  logic [ADDR_MAX_W-1:0] addr, rd_addr, wr_addr, a;
  logic bus_clk, adv_n, sel1_n, sel2_n, oe_n, we_n, dq_oe, nr_out, nr_oe, rd_stb, wr_stb, die_act, rd_mode;
  int n_mismatch = 0, compares = 0, cyc = 0;
  nfbpi_exp_s q[$], e;
  always #25 ref_clk = ~ref_clk;
  nfbpi_ctrl_model ctrl_i (.ref_clk(ref_clk), .bus_clk(bus_clk), .addr(addr), .adv_n(adv_n), .sel1_n(sel1_n),
    .sel2_n(sel2_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in));
  nfbpi_top #(.DENSITY(DENS_256M)) nfbpi_top_i (.REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(1'h1),
    .BUS_CLK(bus_clk), .ADDR(addr), .ADDR_VALID_STROBE_N(adv_n), .DIE_SELECT_FIRST_N(sel1_n),
    .DIE_SELECT_SECOND_N(sel2_n), .OUTPUT_DRIVE_ENABLE_FIRST_N(oe_n), .OUTPUT_DRIVE_ENABLE_SECOND_N(oe_n),
    .WRITE_STROBE_N(we_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .NOT_READY_OUT(nr_out),
    .NOT_READY_OE(nr_oe), .SYNC_MODE_REQ(sync_req), .ASYNC_MODE_REQ(async_req), .READ_CONFIG(rcfg),
    .RD_DATA(rd_data), .RD_DATA_VALID(rd_vld), .RD_ADDR(rd_addr), .RD_ADDR_STB(rd_stb), .WR_STB(wr_stb),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .DIE_ACTIVE(die_act), .READ_MODE(rd_mode));
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'h1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic ok);
    logic [ADDR_MAX_W-1:0] wa;
    logic [DQ_W-1:0] wd;
    wa = ADDR_MAX_W'($urandom) & AMASK;
    wd = DQ_W'($urandom);
    if (ok) q.push_back('{1'h1, wa, wd});
    ctrl_i.wr(s, wa, wd);
  endtask
  ////////////////////////////////////////
  // A strobe with no note waiting is a capture that should have been refused.
  always @(posedge ref_clk) begin
    #2;
    if (wr_stb === 1'h1 || rd_stb === 1'h1) begin
      if (q.size() == 0) chk(1'h0, "unexpected strobe");
      else begin
        e = q.pop_front();
        if (e.w) chk(wr_stb === 1'h1 && wr_addr === e.a && wr_data === e.d, "write capture");
        else chk(rd_stb === 1'h1 && rd_addr === e.a, "sync capture");
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(25097));
    tick(5);
    rst_b = 1'h1;
    tick(1);
    chk(rd_mode === 1'h0 && dq_oe === 1'h0, "reset state");
    a = ADDR_MAX_W'($urandom) | 25'h1000000;
    ctrl_i.pins(2'h2, 1'h1, 1'h0, a);
    tick(3);
    chk(rd_addr === (a & AMASK), "flow through");
    ctrl_i.pins(2'h2, 1'h1, 1'h1, a);
    ctrl_i.pins(2'h2, 1'h1, 1'h1, ~a);
    tick(3);
    chk(rd_addr === (a & AMASK), "latched");
    ctrl_i.pins(2'h3, 1'h1, 1'h0, a);
    for (int i = 0; i < 4; i++) wr(i[0] ? 2'h1 : 2'h2, 1'h1);
    wr(2'h3, 1'h0);
    sync_req = 1'h1;
    tick(1);
    sync_req = 1'h0;
    tick(1);
    chk(rd_mode === 1'h1, "sync mode");
    a = ADDR_MAX_W'($urandom) | 25'h1000000;
    q.push_back('{1'h0, a & AMASK, 16'h0000});
    ctrl_i.cap(a);
    a = ADDR_MAX_W'($urandom);
    q.push_back('{1'h0, a & AMASK, 16'h0000});
    ctrl_i.rise(a);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        rcfg = RCR_W'($urandom);
        rcfg[RCR_POL_BIT] = k[1];
        rd_data = DQ_W'($urandom);
        rd_vld = k[0];
        ctrl_i.pins(2'h2, 1'h0, 1'h0, a);
        tick(2);
        chk(dq_oe === 1'h1 && nr_oe === 1'h1 && dq_out === rd_data, "read drive");
        chk(nr_out === ((m == 0 && !k[0]) ? k[1] : !k[1]), "not ready");
      end
      async_req = 1'h1;
      tick(1);
      async_req = 1'h0;
    end
    ctrl_i.pins(2'h2, 1'h1, 1'h0, a);
    tick(2);
    chk(dq_oe === 1'h0 && nr_oe === 1'h0, "output enable off");
    ctrl_i.pins(2'h3, 1'h0, 1'h0, a);
    tick(2);
    chk(dq_oe === 1'h0 && nr_oe === 1'h0 && die_act === 1'h0, "deselected");
    ctrl_i.pins(2'h3, 1'h1, 1'h0, a);
    sync_req = 1'h1;
    tick(1);
    sync_req = 1'h0;
    rst_b = 1'h0;
    wr(2'h2, 1'h0);
    tick(2);
    rst_b = 1'h1;
    tick(1);
    chk(rd_mode === 1'h0, "mode after reset");
    wr(2'h2, 1'h1);
    tick(4);
    results();
  end
endmodule
